// ### rtl/iss_regs.svh
// Offsets, field positions and reset values of the irq0 source status block
`ifndef ISS_REGS_SVH
`define ISS_REGS_SVH
// ==========================================================
// Register byte offsets
`define ISS_OFF_STATUS 8'h00
`define ISS_OFF_CLEAR 8'h04
`define ISS_OFF_MASK 8'h08
`define ISS_OFF_BULK 8'h0c
`define ISS_OFF_AUTO 8'h10
// ==========================================================
// Field positions in irq0_event_sources
`define ISS_BIT_USB 7
`define ISS_BIT_SETUP 6
`define ISS_BIT_RSVD 5
`define ISS_BIT_DRIVE 4
`define ISS_BIT_BOUT 3
`define ISS_BIT_AOUT 2
`define ISS_BIT_BIN 1
`define ISS_BIT_AIN 0
// Field positions in control registers
`define ISS_BIT_HALF 0
`define ISS_BIT_AUTO 0
// ==========================================================
// Reset values
`define ISS_STAT_RST 8'h0c
`define ISS_MASK_RST 8'hff
`define ISS_HALF_RST 1'b0
`define ISS_AUTO_RST 1'b0
`endif

// ### rtl/iss_pkg.sv
// Types shared by the irq0 source status block
package iss_pkg;
	typedef enum logic [0:0] {
		ISS_SETUP_IDLE = 1'b0,
		ISS_SETUP_DIP = 1'b1
	} iss_setup_state_t;
	typedef logic [7:0] iss_byte_t;
endpackage

// ### rtl/iss_sync.sv
// Three-stage synchroniser with agreement filter for an outside level
`timescale 1ns/10ps
module iss_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic pin,
	output logic level
);
	import iss_pkg::*;
	logic s1_q, s2_q, s3_q, level_q;
	logic agree;
	// First stage is seen only by the second
	assign agree = (s2_q == s3_q);
	assign level = level_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree) begin
				level_q <= s3_q;
			end
		end
	end
endmodule

// ### rtl/iss_apb.sv
// APB slave address decode and handshake for the irq0 source status block
`timescale 1ns/10ps
`include "iss_regs.svh"
module iss_apb (
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	output logic pready,
	output logic pslverr,
	output logic wr_stb,
	output logic rd_cap,
	output logic [4:0] hit
);
	import iss_pkg::*;
	logic mapped;
	logic access;
	assign hit[0] = (paddr == `ISS_OFF_STATUS);
	assign hit[1] = (paddr == `ISS_OFF_CLEAR);
	assign hit[2] = (paddr == `ISS_OFF_MASK);
	assign hit[3] = (paddr == `ISS_OFF_BULK);
	assign hit[4] = (paddr == `ISS_OFF_AUTO);
	assign mapped = |hit;
	assign access = psel & penable;
	// Zero wait states; read data is caught in the setup cycle
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign wr_stb = access & pwrite & mapped;
	assign rd_cap = psel & ~penable & ~pwrite;
endmodule

// ### rtl/iss_top.sv
// Interrupt-0 source status register, mask and core interrupt request
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "iss_regs.svh"
// How it works
// - Bit 7 is read-only and mirrors the USB bus event summary input, unaffected by writes.
// - A SETUP packet sets bit 6 and never raises the endpoint-0 receive flag.
// - A SETUP arriving while bit 6 is set drops bit 6 for one cycle, then sets it again.
// - Bit 6 clears on a written one, and while set the endpoint-0 buffer refuses data.
// - Once bit 6 is clear and the duplicate dip is over, each endpoint-0 data packet arriving without a SETUP pulses the receive flag set output.
// - Bit 5 always reads zero and ignores writes.
// - A rising drive interrupt pin, after synchronising, sets bit 4.
// - Buffer B output done sets bit 3; writing one to the read half select clears it.
// - Buffer A output done sets bit 2; writing zero to the read half select clears it.
// - Buffer B input done sets bit 1.
// - Buffer A input done sets bit 0.
// - In auto transfer mode the transfer engine may clear bits 1 and 0 itself.
// - Writing one to a bit other than 7 returns it to its reset value; zero leaves it.
// - The core interrupt is high while any status bit is set with its mask bit clear.
// - Mask bits only gate the interrupt; status bits still set.
module iss_top (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic usb_event_summary,
	input wire logic setup_rcvd,
	input wire logic ep0_data_rcvd,
	output logic ep0_accept,
	output logic ctrl_ep_rx_done_set,
	input wire logic drive_irq_pin,
	input wire logic buf_b_out_done,
	input wire logic buf_a_out_done,
	input wire logic buf_b_in_done,
	input wire logic buf_a_in_done,
	input wire logic auto_clr_b_in,
	input wire logic auto_clr_a_in,
	output logic auto_xfer_active,
	output logic read_half_select,
	output iss_pkg::iss_byte_t irq0_event_sources,
	output logic core_irq0_input
);
	import iss_pkg::*;

	// ==========================================================
	// Bus decode
	logic wr_stb, rd_cap;
	logic [4:0] hit;
	iss_apb u_apb (
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.pslverr(pslverr),
		.wr_stb(wr_stb),
		.rd_cap(rd_cap),
		.hit(hit)
	);

	logic wr_clr, wr_mask, wr_bulk, wr_auto;
	iss_byte_t w1;
	assign wr_clr = wr_stb & hit[1];
	assign wr_mask = wr_stb & hit[2];
	assign wr_bulk = wr_stb & hit[3];
	assign wr_auto = wr_stb & hit[4];
	// Write-one requests return a bit to its reset value
	assign w1 = wr_clr ? pwdata[7:0] : 8'h00;

	// ==========================================================
	// Drive interrupt pin
	logic drive_lvl, drive_lvl_q, drive_rise;
	iss_sync u_sync (
		.clk(clk),
		.reset(reset),
		.pin(drive_irq_pin),
		.level(drive_lvl)
	);
	// Edge, so a held pin does not refill the flag after clear
	assign drive_rise = drive_lvl & ~drive_lvl_q;

	// ==========================================================
	// Control registers
	iss_byte_t mask_q, mask_d;
	logic half_q, half_d, auto_q, auto_d;
	assign mask_d = wr_mask ? pwdata[7:0] : mask_q;
	assign half_d = wr_bulk ? pwdata[`ISS_BIT_HALF] : half_q;
	assign auto_d = wr_auto ? pwdata[`ISS_BIT_AUTO] : auto_q;
	assign read_half_select = half_q;
	assign auto_xfer_active = auto_q;

	// ==========================================================
	// Sticky flags
	localparam iss_byte_t POR = `ISS_STAT_RST;

	function automatic logic flag_nxt(
		input logic q,
		input logic set,
		input logic restore,
		input logic por,
		input logic zero
	);
		logic r;
		r = q;
		// Set beats any clear arriving in the same cycle
		if (set) begin
			r = 1'b1;
		end else if (restore) begin
			r = por;
		end else if (zero) begin
			r = 1'b0;
		end
		return r;
	endfunction

	iss_byte_t stat_q, stat_d;
	logic tog_one, tog_zero, auto_b, auto_a;
	assign tog_one = wr_bulk & pwdata[`ISS_BIT_HALF];
	assign tog_zero = wr_bulk & ~pwdata[`ISS_BIT_HALF];
	assign auto_b = auto_q & auto_clr_b_in;
	assign auto_a = auto_q & auto_clr_a_in;

	assign stat_d[`ISS_BIT_USB] = 1'b0;
	assign stat_d[`ISS_BIT_RSVD] = 1'b0;
	// Setup flag lives in setup_q, so this bit stays idle
	assign stat_d[`ISS_BIT_SETUP] = 1'b0;
	assign stat_d[`ISS_BIT_DRIVE] = flag_nxt(stat_q[`ISS_BIT_DRIVE], drive_rise,
		w1[`ISS_BIT_DRIVE], POR[`ISS_BIT_DRIVE], 1'b0);
	assign stat_d[`ISS_BIT_BOUT] = flag_nxt(stat_q[`ISS_BIT_BOUT], buf_b_out_done,
		w1[`ISS_BIT_BOUT], POR[`ISS_BIT_BOUT], tog_one);
	assign stat_d[`ISS_BIT_AOUT] = flag_nxt(stat_q[`ISS_BIT_AOUT], buf_a_out_done,
		w1[`ISS_BIT_AOUT], POR[`ISS_BIT_AOUT], tog_zero);
	assign stat_d[`ISS_BIT_BIN] = flag_nxt(stat_q[`ISS_BIT_BIN], buf_b_in_done,
		w1[`ISS_BIT_BIN], POR[`ISS_BIT_BIN], auto_b);
	assign stat_d[`ISS_BIT_AIN] = flag_nxt(stat_q[`ISS_BIT_AIN], buf_a_in_done,
		w1[`ISS_BIT_AIN], POR[`ISS_BIT_AIN], auto_a);

	// ==========================================================
	// SETUP flag with duplicate dip
	iss_setup_state_t st_q, st_d;
	logic setup_q, setup_d;
	always_comb begin
		st_d = st_q;
		setup_d = setup_q;
		case (st_q)
			ISS_SETUP_IDLE: begin
				if (setup_rcvd && setup_q) begin
					setup_d = 1'b0;
					st_d = ISS_SETUP_DIP;
				end else if (setup_rcvd) begin
					setup_d = 1'b1;
				end else if (w1[`ISS_BIT_SETUP]) begin
					setup_d = POR[`ISS_BIT_SETUP];
				end
			end
			ISS_SETUP_DIP: begin
				// Rise again whatever else happens this cycle
				setup_d = 1'b1;
				st_d = ISS_SETUP_IDLE;
			end
			default: begin
				setup_d = 1'b0;
				st_d = ISS_SETUP_IDLE;
			end
		endcase
	end

	// Buffer stays closed through the dip as well
	assign ep0_accept = ~setup_q & (st_q == ISS_SETUP_IDLE);
	logic rx_set_d;
	assign rx_set_d = ep0_data_rcvd & ep0_accept & ~setup_rcvd;

	// ==========================================================
	// Status view and interrupt
	iss_byte_t stat_view;
	assign stat_view = {usb_event_summary, setup_q, 1'b0, stat_q[4:0]};
	assign irq0_event_sources = stat_view;
	// Mask gates only the request, never the flag
	assign core_irq0_input = |(stat_view & ~mask_q);

	// ==========================================================
	// Read data
	iss_byte_t rd_byte;
	assign rd_byte = hit[0] ? stat_view :
		hit[2] ? mask_q :
		hit[3] ? {7'h00, half_q} :
		hit[4] ? {7'h00, auto_q} : 8'h00;

	// ==========================================================
	// Flip-flops
	always_ff @(posedge clk) begin
		if (reset) begin
			stat_q <= `ISS_STAT_RST;
			setup_q <= 1'b0;
			st_q <= ISS_SETUP_IDLE;
			mask_q <= `ISS_MASK_RST;
			half_q <= `ISS_HALF_RST;
			auto_q <= `ISS_AUTO_RST;
			drive_lvl_q <= 1'b0;
			ctrl_ep_rx_done_set <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			stat_q <= stat_d;
			setup_q <= setup_d;
			st_q <= st_d;
			mask_q <= mask_d;
			half_q <= half_d;
			auto_q <= auto_d;
			drive_lvl_q <= drive_lvl;
			ctrl_ep_rx_done_set <= rx_set_d;
			if (rd_cap) begin
				prdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_usb_mirror: assert property (
		rd_cap && hit[0] |=> prdata[7] == $past(usb_event_summary))
		else $error("bit 7 does not follow usb summary");

	chk_setup_first: assert property (
		setup_rcvd && !setup_q && st_q == ISS_SETUP_IDLE |=> setup_q && !ctrl_ep_rx_done_set)
		else $error("setup did not set bit 6");

	chk_setup_dip: assert property (
		setup_rcvd && setup_q && st_q == ISS_SETUP_IDLE |=> !setup_q ##1 setup_q)
		else $error("duplicate setup dip missing");

	chk_ep0_block: assert property (
		setup_q && !w1[6] |=> !ep0_accept)
		else $error("endpoint 0 open while setup pending");

	chk_rx_flag: assert property (
		ep0_data_rcvd && ep0_accept && !setup_rcvd |=> ctrl_ep_rx_done_set ##1 1'b1)
		else $error("receive flag not raised");

	chk_rsvd_zero: assert property (
		$past(rd_cap) |-> prdata[31:8] == 24'h00_0000 && (!$past(hit[0]) || !prdata[5]))
		else $error("reserved bits not zero");

	chk_drive_set: assert property (
		$rose(drive_lvl) |=> stat_q[4])
		else $error("drive interrupt not captured");

	chk_tog_one: assert property (
		wr_bulk && pwdata[0] && !buf_b_out_done |=> !stat_q[3] && read_half_select)
		else $error("bit 3 not cleared by toggle one");

	chk_tog_zero: assert property (
		wr_bulk && !pwdata[0] && !buf_a_out_done |=> !stat_q[2] && !read_half_select)
		else $error("bit 2 not cleared by toggle zero");

	chk_in_set: assert property (
		buf_b_in_done |=> stat_q[1])
		else $error("bit 1 not set");

	chk_in_a_set: assert property (
		buf_a_in_done |=> stat_q[0])
		else $error("bit 0 not set");

	chk_auto_clr: assert property (
		auto_q && auto_clr_a_in && !buf_a_in_done |=> !stat_q[0])
		else $error("auto clear of bit 0 failed");

	chk_w1_restore: assert property (
		wr_clr && pwdata[3] && !buf_b_out_done |=> stat_q[3])
		else $error("write one did not restore reset value");

	chk_irq_raise: assert property (
		buf_a_in_done && !mask_q[0] && !wr_mask |=> core_irq0_input)
		else $error("interrupt not raised");

	chk_mask_keep: assert property (
		buf_b_in_done && mask_q[1] |=> stat_q[1])
		else $error("mask blocked status");

	chk_rx_blocked: assert property (
		!ep0_accept |=> !ctrl_ep_rx_done_set)
		else $error("receive flag raised while endpoint 0 closed");

	chk_setup_clear: assert property (
		w1[6] && setup_q && !setup_rcvd && st_q == ISS_SETUP_IDLE
		|=> !setup_q && ep0_accept)
		else $error("write one did not clear bit 6");

	chk_setup_hold: assert property (
		setup_q && !setup_rcvd && !w1[6] && st_q == ISS_SETUP_IDLE |=> setup_q)
		else $error("bit 6 dropped without a clear");

	chk_dip_rise: assert property (
		st_q == ISS_SETUP_DIP |=> setup_q && st_q == ISS_SETUP_IDLE)
		else $error("bit 6 did not rise after dip");

	chk_rd_mask: assert property (
		rd_cap && hit[2] |=> prdata[7:0] == $past(mask_q))
		else $error("mask read data wrong");

	chk_rd_half: assert property (
		rd_cap && hit[3] |=> prdata == {31'h0000_0000, $past(half_q)})
		else $error("bulk control read data wrong");

	chk_rd_auto: assert property (
		rd_cap && hit[4] |=> prdata == {31'h0000_0000, $past(auto_q)})
		else $error("auto control read data wrong");

	chk_clr_reads_zero: assert property (
		rd_cap && hit[1] |=> prdata == 32'h0000_0000)
		else $error("clear register read not zero");

	chk_auto_idle: assert property (
		!auto_q && auto_clr_b_in && stat_q[1] && !wr_clr |=> stat_q[1])
		else $error("bit 1 cleared outside auto mode");

	chk_set_wins: assert property (
		buf_b_in_done && wr_clr && pwdata[1] |=> stat_q[1])
		else $error("clear beat a set of bit 1");

	chk_drive_hold: assert property (
		stat_q[4] && !wr_clr |=> stat_q[4])
		else $error("bit 4 dropped without a clear");

	chk_bout_set: assert property (
		buf_b_out_done |=> stat_q[3])
		else $error("bit 3 not set");

	chk_aout_set: assert property (
		buf_a_out_done |=> stat_q[2])
		else $error("bit 2 not set");

	cov_dip: cover property (setup_rcvd && setup_q ##1 !setup_q ##1 setup_q);
	cov_toggle: cover property (wr_bulk && pwdata[0] && stat_q[3]);
	cov_irq: cover property (!core_irq0_input ##1 core_irq0_input);
	cov_auto: cover property (auto_q && auto_clr_b_in && stat_q[1]);
	cov_setup_clear: cover property (w1[6] && setup_q ##1 ep0_accept);
endmodule

// ### testbench/test_irq0_source_status.sv
// Self-checking bench for the irq0 source status block
`timescale 1ns/10ps
`include "iss_regs.svh"
module test_irq0_source_status;
	import iss_pkg::*;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic usb, pin, accept, rx_set, auto_on, half, irq;
	logic [7:0] paddr, ev;
	logic [31:0] pwdata, prdata, rd, r;
	iss_byte_t stat;
	int st, mask, auto_m, n_mismatch, compares, seed, i;
	iss_top i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.usb_event_summary(usb), .setup_rcvd(ev[6]), .ep0_data_rcvd(ev[7]),
		.ep0_accept(accept), .ctrl_ep_rx_done_set(rx_set), .drive_irq_pin(pin),
		.buf_b_out_done(ev[3]), .buf_a_out_done(ev[2]), .buf_b_in_done(ev[1]),
		.buf_a_in_done(ev[0]), .auto_clr_b_in(ev[5]), .auto_clr_a_in(ev[4]),
		.auto_xfer_active(auto_on), .read_half_select(half), .irq0_event_sources(stat),
		.core_irq0_input(irq));
	// ==========================================================
	// Model and checks
	function automatic logic [7:0] exp_stat();
		return {usb, st[6], 1'b0, st[4:0]};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task check_all();
		chk(stat, exp_stat());
		chk(irq, (exp_stat() & ~mask[7:0]) != 8'h00);
	endtask
	// Request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task clr(input logic [7:0] w);
		apb(1'b1, `ISS_OFF_CLEAR, {24'h0, w});
		st = (st & ~(w & 8'h7f)) | (8'h0c & w & 8'h7f);
	endtask
	task set_mask(input logic [7:0] m);
		apb(1'b1, `ISS_OFF_MASK, {24'h0, m});
		mask = m;
	endtask
	task pulse(input logic [7:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 8'h00;
		#1;
		st = st | v[3:0] | (v[6] ? 8'h40 : 8'h00);
		if (auto_m != 0 && v[4] && !v[0]) st = st & ~1;
		if (auto_m != 0 && v[5] && !v[1]) st = st & ~2;
	endtask
	task results();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		results();
	end
	// ==========================================================
	// Scenarios
	initial begin
		seed = 74;
		{reset, psel, penable, pwrite, usb, pin} = 6'b100000;
		paddr = 8'h00;
		pwdata = 32'h0;
		ev = 8'h00;
		st = 8'h0c;
		mask = 8'hff;
		auto_m = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		#1;
		check_all();
		apb(1'b0, `ISS_OFF_MASK, 32'h0);
		chk(rd, 32'hff);
		$display("reset test done");
		apb(1'b1, `ISS_OFF_BULK, 32'h1);
		st = st & ~8;
		chk(half, 1'b1);
		check_all();
		apb(1'b1, `ISS_OFF_BULK, 32'h0);
		st = st & ~4;
		chk(half, 1'b0);
		check_all();
		clr(8'hff);
		check_all();
		$display("toggle test done");
		set_mask(8'h00);
		for (i = 0; i < 4; i++) begin
			clr(8'h0f);
			apb(1'b1, `ISS_OFF_BULK, {31'h0, i[0]});
			apb(1'b1, `ISS_OFF_BULK, {31'h0, ~i[0]});
			st = st & ~8'h0c;
			check_all();
			pulse(8'h01 << i);
			check_all();
		end
		$display("event test done");
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			set_mask(r[7:0]);
			clr(r[15:8]);
			@(posedge clk);
			usb <= r[16];
			#1;
			pulse({4'h0, r[27:24]});
			check_all();
			apb(1'b0, `ISS_OFF_STATUS, 32'h0);
			chk(rd, {24'h0, exp_stat()});
		end
		$display("random test done");
		pulse(8'h40);
		chk(stat[6], 1'b1);
		chk(accept, 1'b0);
		chk(rx_set, 1'b0);
		pulse(8'h80);
		chk(rx_set, 1'b0);
		pulse(8'h40);
		chk(stat[6], 1'b0);
		@(posedge clk);
		#1;
		chk(stat[6], 1'b1);
		clr(8'h40);
		chk(accept, 1'b1);
		pulse(8'h80);
		chk(rx_set, 1'b1);
		check_all();
		$display("setup test done");
		pulse(8'h03);
		pulse(8'h30);
		check_all();
		apb(1'b1, `ISS_OFF_AUTO, 32'h1);
		auto_m = 1;
		chk(auto_on, 1'b1);
		apb(1'b0, `ISS_OFF_AUTO, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, `ISS_OFF_BULK, 32'h0);
		chk(rd, 32'h0);
		pulse(8'h30);
		check_all();
		$display("auto test done");
		@(posedge clk);
		pin <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		st = st | 8'h10;
		check_all();
		@(posedge clk);
		pin <= 1'b0;
		clr(8'h10);
		check_all();
		$display("drive test done");
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, `ISS_OFF_STATUS, 32'h0);
		apb(1'b0, `ISS_OFF_STATUS, 32'h0);
		chk(rd, {24'h0, exp_stat()});
		chk(err, 1'b0);
		apb(1'b0, `ISS_OFF_CLEAR, 32'h0);
		chk(rd, 32'h0);
		$display("refusal test done");
		results();
	end
endmodule
